//--- src/esp_status_bank.sv
// Functional notes
// [R01] 64-bit status per record, 64-byte stride from 0x010
// [R02] system view: 32/64-bit moves via record selector
// [R03] bits 63:32 and 18:16 read zero
// [R04] unimplemented record reads zero, ignores writes
// [R05] writing zero to local fields quiesces record
// [R06] writing zero drops the syndrome interrupt request
// [R07] interrupting syndrome disabled after cold reset
// [R08] bit 31 address valid, one-to-clear
// [R09] bit 30 recorded flag, one-to-clear
// [R10] bit 29 uncorrected flag, one-to-clear
// [R11] uncorrected and overflow meaningless while unrecorded
// [R12] bit 28 set on in-band error response
// [R13] response flag one-to-clear, valid with UE/DE
// [R14] deferred errors may set response flag
// [R15] overflow set on counter wrap or repeat record
// [R16] overflow otherwise unchanged on recording
// [R17] counter overflow interplay may be undefined
// [R18] software clears UE/OF along with recorded
// [R19] cold reset clears address valid and recorded
// [R20] flags 31:27 kept over recovery reset
// [R21] write one clears, set beats clear
`timescale 1ns/100ps
module esp_status_bank
    import esp_pkg::*;
(
    input  wire logic                        clk,           // 20 MHz system clock
    input  wire logic                        rst_b,         // cold reset, sync, active low
    input  wire logic                        er_rst_b,      // error recovery reset, active low
    input  wire logic                        mm_req,        // memory-mapped access strobe
    input  wire logic                        mm_wr,         // 1 write, 0 read
    input  wire logic [esp_pkg::ADDR_W-1:0]  mm_addr,       // byte address
    input  wire logic [esp_pkg::DATA_W-1:0]  mm_wdata,      // write data
    output logic      [esp_pkg::DATA_W-1:0]  mm_rdata,      // read data
    output logic                             mm_ack,        // one-cycle answer
    input  wire logic                        sr_req,        // system register move strobe
    input  wire logic                        sr_wr,         // 1 write move, 0 read move
    input  wire logic                        sr_wide,       // 1 full 64-bit, 0 low 32-bit
    input  wire logic [esp_pkg::REC_W-1:0]   record_selector, // record chosen for the view
    input  wire logic [esp_pkg::DATA_W-1:0]  sr_wdata,      // move source
    output logic      [esp_pkg::DATA_W-1:0]  selected_status_view, // move result
    output logic                             sr_ack,        // one-cycle answer
    input  wire logic                        ev_valid,      // error recorded this cycle
    input  wire logic [esp_pkg::REC_W-1:0]   ev_rec,        // record that takes it
    input  wire esp_pkg::esp_err_e           ev_type,       // class of the error
    input  wire logic                        ev_addr_valid, // address captured with it
    input  wire logic                        ev_resp,       // in-band response returned
    input  wire logic                        ev_cnt_ovf,    // corrected counter wrapped
    input  wire logic                        ctl_irq_en,    // enable from record control
    output logic                             fault_irq      // fault handling request
);
    import esp_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [NUM_REC-1:0]  av_reg;      // address valid per record
    logic [NUM_REC-1:0]  v_reg;       // recorded per record
    logic [NUM_REC-1:0]  ue_reg;      // uncorrected per record
    logic [NUM_REC-1:0]  er_reg;      // response signaled per record
    logic [NUM_REC-1:0]  of_reg;      // overflow per record
    logic [NUM_REC-1:0]  syn_reg;     // interrupting syndrome per record
    logic                irq_en_reg;  // syndrome interrupt enable
    logic [DATA_W-1:0]   word [NUM_REC]; // assembled status words

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic [ADDR_W-1:0]   mm_off;      // offset from the first copy
    logic [ADDR_W-1:0]   mm_idx_w;    // slot number, wide
    logic                mm_hit;      // maps onto an existing slot
    logic [REC_W-1:0]    mm_idx;      // record addressed

    assign mm_off   = mm_addr - STATUS_BASE;
    assign mm_idx_w = mm_off >> REC_STRIDE_SH;
    assign mm_idx   = mm_idx_w[REC_W-1:0];
    // anything outside a status slot reads zero and drops writes
    assign mm_hit   = (mm_addr >= STATUS_BASE) && (mm_addr[5:0] == STATUS_LOW)
                    && (mm_idx_w < ADDR_W'(NUM_REC)); // [R01]

    // narrow moves zero the upper half of the data; it is all zero anyway
    logic [DATA_W-1:0]   sr_data_m;   // move data, narrowed as needed
    assign sr_data_m = sr_wide ? sr_wdata : {{(DATA_W-LOW_W){1'b0}}, sr_wdata[LOW_W-1:0]}; // [R02]

    // ****************************************************************
    // per-record flag logic
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < NUM_REC; i++)
        begin : g_rec
            logic             wr_mm;   // memory-mapped write to this record
            logic             wr_sr;   // system write to this record
            logic             wr;      // any write, memory-mapped first
            logic [DATA_W-1:0] wd;     // data of that write
            logic             rec;     // error recorded here now
            logic             is_corr; // it was a corrected error
            logic             av_set, v_set, ue_set, er_set, of_set, syn_set;

            // an absent record sees no write and no event
            assign wr_mm = mm_req && mm_wr && mm_hit && (mm_idx == REC_W'(i))
                         && REC_IMPL[i];                                          // [R04]
            assign wr_sr = sr_req && sr_wr && (record_selector == REC_W'(i))
                         && REC_IMPL[i];                                          // [R02]
            assign wr    = wr_mm || wr_sr;
            assign wd    = wr_mm ? mm_wdata : sr_data_m;
            assign rec   = ev_valid && (ev_type != ESP_NONE) && (ev_rec == REC_W'(i))
                         && REC_IMPL[i];
            assign is_corr = (ev_type == ESP_CORRECTED);

            assign av_set = rec && ev_addr_valid && ADDR_SUPPORTED;               // [R08]
            assign v_set  = rec;                                                  // [R09]
            assign ue_set = rec && (ev_type == ESP_UNCORRECTED);                  // [R10]
            // deferred errors are allowed to respond in-band here
            assign er_set = rec && ev_resp && ((ev_type == ESP_UNCORRECTED)
                          || ((ev_type == ESP_DEFERRED) && DEFER_RESP));          // [R12] [R14]
            // counter wrap, or a second error while already recorded (a corrected one counts only when no counter is built)
            assign of_set = rec && ((CNT_IMPL && ev_cnt_ovf)
                          || (v_reg[i] && !is_corr)
                          || (v_reg[i] && is_corr && !CNT_IMPL));                 // [R15]
            assign syn_set = rec && irq_en_reg;

            // flags: hardware set wins over a one-to-clear in the same cycle
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    av_reg[i] <= 1'b0;                                            // [R19]
                    v_reg[i]  <= 1'b0;                                            // [R19]
                    ue_reg[i] <= 1'b0;   // undefined after cold reset, zero chosen
                    er_reg[i] <= 1'b0;
                    of_reg[i] <= 1'b0;
                end
                else
                begin
                    // recovery reset is deliberately not looked at here
                    av_reg[i] <= av_set || (av_reg[i] && !(wr && wd[AV_BIT])); // [R08] [R21] [R20]
                    v_reg[i]  <= v_set  || (v_reg[i]  && !(wr && wd[V_BIT]));  // [R09] [R21]
                    ue_reg[i] <= ue_set || (ue_reg[i] && !(wr && wd[UE_BIT])); // [R10] [R21]
                    er_reg[i] <= er_set || (er_reg[i] && !(wr && wd[ER_BIT])); // [R13] [R21]
                    // other recordings leave overflow alone
                    of_reg[i] <= of_set || (of_reg[i] && !(wr && wd[OF_BIT])); // [R16] [R21]
                end
            end

            // local syndrome: plain field, zero write quiesces and drops the request
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    syn_reg[i] <= 1'b0;
                end
                else if (syn_set)
                begin
                    syn_reg[i] <= 1'b1;
                end
                else if (wr)
                begin
                    syn_reg[i] <= wd[SYN_BIT];                                    // [R05] [R06]
                end
            end

            // reserved bits and absent records assemble to zero
            always_comb
            begin
                word[i] = ZERO_WORD;                                              // [R03]
                if (REC_IMPL[i])                                                  // [R04]
                begin
                    word[i][AV_BIT]  = av_reg[i] && ADDR_SUPPORTED;
                    word[i][V_BIT]   = v_reg[i];
                    // UE/OF are shown raw even while unrecorded; software ignores them
                    word[i][UE_BIT]  = ue_reg[i];                                 // [R11]
                    word[i][ER_BIT]  = er_reg[i];
                    word[i][OF_BIT]  = of_reg[i];                                 // [R17]
                    word[i][SYN_BIT] = syn_reg[i];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // interrupt enable and request
    // ****************************************************************
    // enable tracks the control field but starts off after cold reset;
    // recovery reset also drops it so a stale enable cannot re-fire
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_en_reg <= 1'b0;                                                   // [R07]
        end
        else if (!er_rst_b)
        begin
            irq_en_reg <= 1'b0;
        end
        else
        begin
            irq_en_reg <= ctl_irq_en;
        end
    end

    // request follows the syndrome bits one cycle late
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fault_irq <= 1'b0;
        end
        else
        begin
            fault_irq <= |syn_reg;                                                // [R06]
        end
    end

    // ****************************************************************
    // read paths
    // ****************************************************************
    // memory-mapped answer, one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mm_ack   <= 1'b0;
            mm_rdata <= ZERO_WORD;
        end
        else
        begin
            mm_ack   <= mm_req;
            // unmapped or write: zero data
            mm_rdata <= (mm_req && !mm_wr && mm_hit) ? word[mm_idx] : ZERO_WORD; // [R01] [R03]
        end
    end

    // system view answer; narrow reads return only the low half
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sr_ack               <= 1'b0;
            selected_status_view <= ZERO_WORD;
        end
        else
        begin
            sr_ack <= sr_req;
            if (sr_req && !sr_wr)
            begin
                selected_status_view <= sr_wide ? word[record_selector]
                    : {{(DATA_W-LOW_W){1'b0}}, word[record_selector][LOW_W-1:0]}; // [R02]
            end
            else
            begin
                selected_status_view <= ZERO_WORD;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // record 0 stands for all: every record runs the same generate body
    logic ev0;    // error lands in record 0
    logic wr0;    // memory-mapped write to record 0
    assign ev0 = ev_valid && (ev_type != ESP_NONE) && (ev_rec == '0);
    assign wr0 = mm_req && mm_wr && mm_hit && (mm_idx == '0) && !sr_req;

    // zero write to record 0's syndrome while no other syndrome is pending
    sequence s_zero_syn;
        wr0 && !mm_wdata[SYN_BIT] && !ev_valid && !sr_req && (syn_reg[NUM_REC-1:1] == '0);
    endsequence
    // syndrome gone on the next edge, the request one edge after that
    sequence s_quiet;
        !syn_reg[0] ##1 !fault_irq;
    endsequence

    // reserved bits never show on a memory-mapped read
    property p_hi_zero;
        mm_ack |-> (mm_rdata[63:32] == 32'h0) && (mm_rdata[18:16] == 3'h0);
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("reserved read bits not zero"); // [R03]

    // a read returns the word as it stood on the taking edge
    property p_read_ack;
        mm_req && !mm_wr && mm_hit && (mm_idx == '0) |=> mm_ack && (mm_rdata == $past(word[0]));
    endproperty
    a_read_ack: assert property (p_read_ack) else $error("read answer wrong"); // [R01]

    // any recorded error marks the record valid
    property p_v_set;
        ev0 |=> v_reg[0];
    endproperty
    a_v_set: assert property (p_v_set) else $error("recorded flag not set"); // [R09]

    // a one-write with no competing event clears the recorded flag
    property p_v_clear;
        wr0 && mm_wdata[V_BIT] && !ev_valid |=> !v_reg[0];
    endproperty
    a_v_clear: assert property (p_v_clear) else $error("recorded flag not cleared"); // [R21]

    // a zero in a one-to-clear position leaves the flag alone
    property p_w0_keep;
        wr0 && !mm_wdata[AV_BIT] && av_reg[0] |=> av_reg[0];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("zero write cleared addr valid"); // [R21]

    // hardware set on the same edge as a clear must survive
    property p_set_wins;
        ev0 && (ev_type == ESP_UNCORRECTED) && wr0 && mm_wdata[UE_BIT] |=> ue_reg[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set"); // [R10]

    // a second non-corrected error on a valid record is an overflow
    property p_of_set;
        ev0 && v_reg[0] && (ev_type != ESP_CORRECTED) |=> of_reg[0];
    endproperty
    a_of_set: assert property (p_of_set) else $error("overflow not set"); // [R15]

    // a first recording into an empty record leaves overflow as it was
    property p_of_keep;
        ev0 && !v_reg[0] && !ev_cnt_ovf && !(mm_req && mm_wr) && !(sr_req && sr_wr)
            |=> of_reg[0] == $past(of_reg[0]);
    endproperty
    a_of_keep: assert property (p_of_keep) else $error("overflow changed"); // [R16]

    // an uncorrected error with an in-band response marks both flags
    property p_er_set;
        ev0 && ev_resp && (ev_type == ESP_UNCORRECTED) |=> er_reg[0] && ue_reg[0];
    endproperty
    a_er_set: assert property (p_er_set) else $error("response flag not set"); // [R12]

    // zero write quiesces the syndrome and then drops the request
    property p_irq_drop;
        s_zero_syn |=> s_quiet;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("syndrome not cleared by zero"); // [R06]

    // the request is the registered OR of all syndromes
    property p_irq_follow;
        ##1 fault_irq == $past(|syn_reg);
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("fault request mismatch"); // [R05]
endmodule

//--- src/esp_pkg.sv
package esp_pkg;
    // ****************************************************************
    // record geometry
    // ****************************************************************
    localparam int          NUM_REC      = 4;            // records in this node
    localparam int          REC_W        = 2;            // record index width
    localparam int          ADDR_W       = 12;           // memory-mapped byte address width
    localparam int          DATA_W       = 64;           // register width
    localparam int          LOW_W        = 32;           // narrow system-register move width
    localparam logic [11:0] STATUS_BASE  = 12'h010;      // first status copy
    localparam int          REC_STRIDE_SH = 6;           // copies spaced 64 bytes apart
    localparam logic [5:0]  STATUS_LOW   = 6'h10;        // offset inside each 64-byte slot

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int          AV_BIT       = 31;           // address valid
    localparam int          V_BIT        = 30;           // status valid
    localparam int          UE_BIT       = 29;           // uncorrected
    localparam int          ER_BIT       = 28;           // in-band response signaled
    localparam int          OF_BIT       = 27;           // overflow
    localparam int          SYN_BIT      = 8;            // local interrupting syndrome

    // ****************************************************************
    // build options
    // ****************************************************************
    localparam logic [NUM_REC-1:0] REC_IMPL   = 4'hf;    // implemented records
    localparam logic        ADDR_SUPPORTED    = 1'b1;    // address recording present
    localparam logic        CNT_IMPL          = 1'b0;    // corrected-error counter present
    localparam logic        DEFER_RESP        = 1'b1;    // deferred errors may respond in-band
    localparam logic [DATA_W-1:0] ZERO_WORD   = 64'h0;   // reads of absent state

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        ESP_CORRECTED   = 2'b00,
        ESP_DEFERRED    = 2'b01,
        ESP_UNCORRECTED = 2'b10,
        ESP_NONE        = 2'b11
    } esp_err_e;
endpackage

//--- tb/esp_err_src.sv
`timescale 1ns/100ps
// ****************************************************************
// error detection side: records one error per call of raise
// ****************************************************************
module esp_err_src
    import esp_pkg::*;
(
    input  wire logic                      clk,           // system clock
    output logic                           ev_valid,      // one-cycle event pulse
    output logic      [esp_pkg::REC_W-1:0] ev_rec,        // record hit by the error
    output esp_pkg::esp_err_e              ev_type,       // class of the error
    output logic                           ev_addr_valid, // address captured
    output logic                           ev_resp,       // in-band response returned
    output logic                           ev_cnt_ovf     // no counter built, stays low
);
    import esp_pkg::*;

    // idle lines carry the none class so a stray sample records nothing
    initial
    begin
        ev_valid = 1'b0;
        ev_rec = 2'h0;
        ev_type = ESP_NONE;
        ev_addr_valid = 1'b0;
        ev_resp = 1'b0;
        ev_cnt_ovf = 1'b0;
    end

    // drive after a falling edge, hold over one taking edge, then scramble
    task automatic raise(input logic [1:0] rec, input esp_err_e typ, input logic av,
                         input logic resp);
        @(negedge clk);
        ev_valid = 1'b1;
        ev_rec = rec;
        ev_type = typ;
        ev_addr_valid = av;
        ev_resp = resp;
        @(negedge clk);
        ev_valid = 1'b0;
        ev_type = ESP_NONE;
        ev_rec = ~rec;
        ev_addr_valid = ~av;
        ev_resp = ~resp;
    endtask
endmodule

//--- tb/error_record_primary_status_tb_top.sv
`timescale 1ns/100ps
module error_record_primary_status_tb_top;
    import esp_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic              clk, rst_b, er_rst_b, ctl_irq_en, fault_irq;
    logic              mm_req, mm_wr, mm_ack, sr_req, sr_wr, sr_wide, sr_ack;
    logic [11:0]       mm_addr;       // byte address
    logic [1:0]        record_selector; // system view record
    logic [63:0]       mm_wdata, mm_rdata, sr_wdata, selected_status_view;
    logic              ev_valid, ev_addr_valid, ev_resp, ev_cnt_ovf;
    logic [1:0]        ev_rec;        // record of the event
    esp_err_e          ev_type;       // class of the event
    int                num_errors, num_checks;
    localparam logic [63:0] F_AV = 64'h1 << AV_BIT;
    localparam logic [63:0] F_V  = 64'h1 << V_BIT;
    localparam logic [63:0] F_UE = 64'h1 << UE_BIT;
    localparam logic [63:0] F_ER = 64'h1 << ER_BIT;
    localparam logic [63:0] F_OF = 64'h1 << OF_BIT;
    localparam logic [63:0] F_SY = 64'h1 << SYN_BIT;

    esp_status_bank dut_u (.clk(clk), .rst_b(rst_b), .er_rst_b(er_rst_b), .mm_req(mm_req),
        .mm_wr(mm_wr), .mm_addr(mm_addr), .mm_wdata(mm_wdata), .mm_rdata(mm_rdata),
        .mm_ack(mm_ack), .sr_req(sr_req), .sr_wr(sr_wr), .sr_wide(sr_wide),
        .record_selector(record_selector), .sr_wdata(sr_wdata),
        .selected_status_view(selected_status_view), .sr_ack(sr_ack), .ev_valid(ev_valid),
        .ev_rec(ev_rec), .ev_type(ev_type), .ev_addr_valid(ev_addr_valid), .ev_resp(ev_resp),
        .ev_cnt_ovf(ev_cnt_ovf), .ctl_irq_en(ctl_irq_en), .fault_irq(fault_irq));
    esp_err_src pe_u (.clk(clk), .ev_valid(ev_valid), .ev_rec(ev_rec), .ev_type(ev_type),
        .ev_addr_valid(ev_addr_valid), .ev_resp(ev_resp), .ev_cnt_ovf(ev_cnt_ovf));

    // 50 ns period
    always #25 clk = ~clk;

    // ****************************************************************
    // reporting
    // ****************************************************************
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one access on either view; writes must also answer with zero data
    task automatic reg_op(input logic sys, input logic wr, input logic wide,
                          input logic [11:0] addr, input logic [63:0] wd,
                          input logic [63:0] exp);
        int n;
        @(negedge clk);
        mm_req = !sys;
        sr_req = sys;
        mm_wr = wr;
        sr_wr = wr;
        sr_wide = wide;
        mm_addr = addr;
        record_selector = addr[1:0];
        mm_wdata = wd;
        sr_wdata = wd;
        @(negedge clk);
        mm_req = 1'b0;
        sr_req = 1'b0;
        n = 0;
        // the answer is a one-cycle pulse, so look at every falling edge
        while ((sys ? sr_ack : mm_ack) !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 4)
        begin
            num_errors++;
            tally_and_finish();
        end
        else
        begin
            chk64(sys ? selected_status_view : mm_rdata, exp);
        end
    endtask

    task automatic rd(input int rec, input logic [63:0] exp);
        reg_op(1'b0, 1'b0, 1'b1, STATUS_BASE + 12'(rec * 64), 64'h0, exp);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        for (int r = 0; r < NUM_REC; r++)
            rd(r, 64'h0);
        reg_op(1'b0, 1'b0, 1'b1, 12'h018, 64'h0, 64'h0);
        reg_op(1'b1, 1'b0, 1'b0, 12'h003, 64'h0, 64'h0);
    endtask

    // irq enable is low, so no syndrome bit may appear here
    task automatic t_record;
        pe_u.raise(2'h1, ESP_UNCORRECTED, 1'b1, 1'b1);
        rd(1, F_AV | F_V | F_UE | F_ER);
        reg_op(1'b1, 1'b0, 1'b1, 12'h001, 64'h0, F_AV | F_V | F_UE | F_ER);
        pe_u.raise(2'h1, ESP_CORRECTED, 1'b0, 1'b0);
        reg_op(1'b1, 1'b0, 1'b0, 12'h001, 64'h0, F_AV|F_V|F_UE|F_ER|F_OF);
        pe_u.raise(2'h2, ESP_DEFERRED, 1'b0, 1'b1);
        rd(2, F_V | F_ER);
        pe_u.raise(2'h3, ESP_CORRECTED, 1'b0, 1'b0);
        rd(3, F_V);
    endtask

    // recovery reset keeps flags, then one-writes clear them
    task automatic t_clear;
        @(negedge clk);
        er_rst_b = 1'b0;
        @(negedge clk);
        er_rst_b = 1'b1;
        rd(1, F_AV | F_V | F_UE | F_ER | F_OF);
        reg_op(1'b0, 1'b1, 1'b1, 12'h050, 64'hffffffff_f8070000, 64'h0);
        rd(1, 64'h0);
        // the response flag of record 2 needs its own one, bit 28
        reg_op(1'b1, 1'b1, 1'b0, 12'h002, 64'hffffffff_f0000000, 64'h0);
        rd(2, 64'h0);
    endtask

    // a hardware set on the same edge as a one-write clear wins
    task automatic t_race;
        fork
            pe_u.raise(2'h3, ESP_UNCORRECTED, 1'b0, 1'b0);
            reg_op(1'b0, 1'b1, 1'b1, 12'h0d0, F_V, 64'h0);
        join
        rd(3, F_V | F_UE | F_OF);
        // same race on record 0, against its type and response flags
        fork
            pe_u.raise(2'h0, ESP_UNCORRECTED, 1'b1, 1'b1);
            reg_op(1'b0, 1'b1, 1'b1, 12'h010, F_UE | F_ER, 64'h0);
        join
        rd(0, F_AV | F_V | F_UE | F_ER);
        pe_u.raise(2'h0, ESP_DEFERRED, 1'b0, 1'b0);
        rd(0, F_AV | F_V | F_UE | F_ER | F_OF);
        // empty record 0 but keep its address flag for the zero-write checks
        reg_op(1'b0, 1'b1, 1'b1, 12'h010, F_V | F_UE | F_ER | F_OF, 64'h0);
        rd(0, F_AV);
    endtask

    // syndrome raises the request; a zero write drops it
    task automatic t_irq;
        @(negedge clk);
        ctl_irq_en = 1'b1;
        pe_u.raise(2'h0, ESP_CORRECTED, 1'b0, 1'b0);
        @(negedge clk);
        chk64({63'h0, fault_irq}, 64'h1);
        rd(0, F_AV | F_V | F_SY);
        reg_op(1'b0, 1'b1, 1'b1, 12'h010, 64'h0, 64'h0);
        @(negedge clk);
        chk64({63'h0, fault_irq}, 64'h0);
        rd(0, F_AV | F_V);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        er_rst_b = 1'b1;
        ctl_irq_en = 1'b0;
        mm_req = 1'b0;
        mm_wr = 1'b0;
        mm_addr = 12'h0;
        mm_wdata = 64'h0;
        sr_req = 1'b0;
        sr_wr = 1'b0;
        sr_wide = 1'b0;
        record_selector = 2'h0;
        sr_wdata = 64'h0;
        num_errors = 0;
        num_checks = 0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_record();
        t_clear();
        t_race();
        t_irq();
        tally_and_finish();
    end
endmodule
